// *** logic/irpt_timer.sv ***
// 8-bit IR pulse timer with shared transmit/demodulation control over APB.
// Behaviour
// - Terminal-count interrupt asserted only while interrupt-mask bit is 1; reset clears it.
// - Control bit 0 low keeps port output on pin; high drives timer output.
// - Writing 1 to enable field starts the 8-bit timer.
// - Pass field 0 reloads at terminal count; 1 stops there.
// - Timeout status sets at terminal count; only a write of 1 clears it.
// - First count tick after enable may come at any time.
// - Transmit sub-mode: normal, ping-pong, force 16-bit output low, force high.
// - Demodulation sub-mode selects glitch filter: none, 4 or 8 cycles.
// - Common bits 1 and 0 give initial 8-bit and 16-bit output levels; code applies bit 1 only, bit 0 sets no 16-bit output level.
// - Demodulation rise/fall flags set on edges; writing 1 clears them.
// - Mode field 0 means transmit, any other value demodulation.
// - Transmit routing bit puts combined timer output on the shared pin.
// - Demodulation routing bit selects port-2 or port-3 input pin.
// - Port-3 input capture may also raise interrupt request two.
// - On enable output takes initial level, then loads low or high reload.
// - Single pass counts to 0, stops, toggles, sets timeout, interrupts.
// - Repeating mode toggles, then reloads low or high by new level.
// - Repeating: first terminal count toggles only; second also sets timeout.
// - Reload registers writable anytime; used at next load only.
// - Start count 0 wraps to FFH, giving 256 steps.
//
// Implementation choice: register access over APB.
module irpt_timer
  import irpt_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        tick_i,
  input  wire logic        port_out_34_i,
  input  wire logic        port_out_36_i,
  input  wire logic        timer16_out_i,
  input  wire logic        port2_input_pin_i,
  input  wire logic        port3_input_pin_i,
  output logic             timer_output_pin_o,
  output logic             combined_output_pin_o,
  output logic             sixteen_bit_timer_output_o,
  output logic             demod_signal_o,
  output logic             timeout_irq_o,
  output logic             irq_two_capture_o
);

  irpt_apb_req_t req;
  irpt_apb_rsp_t rsp;
  assign req = '{psel: psel_i, penable: penable_i, pwrite: pwrite_i, paddr: paddr_i, pwdata: pwdata_i};

  logic [7:0]  ctrl8_ff;
  logic [7:0]  common_ff;
  logic [7:0]  high_ff;
  logic [7:0]  low_ff;
  logic [7:0]  cnt_ff;
  logic        out8_ff;
  logic        half_ff;
  logic        tout_ff;
  logic        rise_ff;
  logic        fall_ff;
  logic        irq_ff;
  logic        filt_ff;
  logic        raw_ff;
  logic [3:0]  fcnt_ff;
  logic [31:0] rdata_ff;
  irpt_state_t state_ff;

  logic wr_acc;
  logic rd_acc;
  logic hit;
  logic demod;
  logic tc;
  logic start;
  logic tout_ev;
  logic raw_in;
  logic [3:0] flen;
  logic [7:0] nxt_load;

  assign hit    = (req.paddr == IRPT_OFF_CTRL8) || (req.paddr == IRPT_OFF_COMMON) ||
                  (req.paddr == IRPT_OFF_HIGH) || (req.paddr == IRPT_OFF_LOW) ||
                  (req.paddr == IRPT_OFF_STAT);
  assign wr_acc = ce_i && req.psel && req.penable && req.pwrite;
  assign rd_acc = ce_i && req.psel && !req.penable && !req.pwrite;
  assign demod  = |common_ff[IRPT_C1_MODEHI:IRPT_C1_MODELO];
  assign start  = wr_acc && (req.paddr == IRPT_OFF_CTRL8) && req.pwdata[IRPT_C0_EN];
  assign tc     = (state_ff == IRPT_COUNT) && tick_i && (cnt_ff == IRPT_CNT_ONE);
  assign nxt_load = !out8_ff ? high_ff : low_ff;
  assign tout_ev = tc && (ctrl8_ff[IRPT_C0_SINGLE] || half_ff);

  // APB: writes take effect in the access phase; read data is latched in setup.
  assign rsp = '{prdata: rdata_ff, pready: 1'b1, pslverr: req.psel && req.penable && !hit};
  assign pready_o    = rsp.pready;
  assign pslverr_o   = rsp.pslverr;
  assign prdata_o    = rsp.prdata;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_ff <= '0;
    end else if (rd_acc) begin
      case (req.paddr)
        IRPT_OFF_CTRL8:  rdata_ff <= {24'h0, ctrl8_ff[7:6], tout_ff, ctrl8_ff[4:0]};
        IRPT_OFF_COMMON: rdata_ff <= demod ? {24'h0, common_ff[7:2], rise_ff, fall_ff} : {24'h0, common_ff};
        IRPT_OFF_HIGH:   rdata_ff <= {24'h0, high_ff};
        IRPT_OFF_LOW:    rdata_ff <= {24'h0, low_ff};
        IRPT_OFF_STAT:   rdata_ff <= {24'h0, cnt_ff};
        default:         rdata_ff <= '0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctrl8_ff  <= IRPT_RST_BYTE;
      common_ff <= IRPT_RST_BYTE;
    end else if (wr_acc) begin
      if (req.paddr == IRPT_OFF_CTRL8) begin
        ctrl8_ff <= {req.pwdata[7:6], 1'b0, req.pwdata[4:0]};
      end
      if (req.paddr == IRPT_OFF_COMMON) begin
        common_ff <= req.pwdata[7:0];
      end
    end
  end

  // Reload registers only feed the counter at a load, so a write lands at the next load.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      high_ff <= IRPT_RST_BYTE;
      low_ff  <= IRPT_RST_BYTE;
    end else if (wr_acc) begin
      if (req.paddr == IRPT_OFF_HIGH) begin
        high_ff <= req.pwdata[7:0];
      end
      if (req.paddr == IRPT_OFF_LOW) begin
        low_ff <= req.pwdata[7:0];
      end
    end
  end

  // Counting FSM; the first tick may arrive any cycle after the load.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_ff <= IRPT_IDLE;
      cnt_ff   <= IRPT_CNT_ZERO;
      out8_ff  <= 1'b0;
      half_ff  <= 1'b0;
    end else if (ce_i) begin
      if (start) begin
        out8_ff  <= common_ff[IRPT_C1_INIT8];
        cnt_ff   <= common_ff[IRPT_C1_INIT8] ? high_ff : low_ff;
        half_ff  <= 1'b0;
        state_ff <= IRPT_COUNT;
      end else begin
        case (state_ff)
          IRPT_COUNT: begin
            if (tc) begin
              out8_ff <= !out8_ff;
              if (ctrl8_ff[IRPT_C0_SINGLE]) begin
                cnt_ff   <= IRPT_CNT_ZERO;
                state_ff <= IRPT_DONE;
              end else begin
                cnt_ff  <= nxt_load;
                half_ff <= !half_ff;
              end
            end else if (tick_i) begin
              cnt_ff <= cnt_ff - 8'h01;
            end
          end
          IRPT_DONE: state_ff <= IRPT_DONE;
          IRPT_IDLE: state_ff <= IRPT_IDLE;
          default:   state_ff <= IRPT_IDLE;
        endcase
      end
    end
  end

  // Timeout status: a terminal count in the clearing cycle wins.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tout_ff <= 1'b0;
    end else if (ce_i) begin
      if (tout_ev) begin
        tout_ff <= 1'b1;
      end else if (wr_acc && req.paddr == IRPT_OFF_CTRL8 && req.pwdata[IRPT_C0_TOUT]) begin
        tout_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      irq_ff <= 1'b0;
    end else if (ce_i) begin
      irq_ff <= tout_ev && ctrl8_ff[IRPT_C0_IMASK];
    end
  end
  assign timeout_irq_o = irq_ff;

  // Demodulation input select and glitch filter.
  assign raw_in = common_ff[IRPT_C1_SEL] ? port3_input_pin_i : port2_input_pin_i;
  always_comb begin
    case (common_ff[IRPT_C1_SUBHI:IRPT_C1_SUBLO])
      IRPT_SUB_PING: flen = IRPT_FILT4_CYC;
      IRPT_SUB_LOW:  flen = IRPT_FILT8_CYC;
      default:       flen = 4'h0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      raw_ff  <= 1'b0;
      fcnt_ff <= 4'h0;
      filt_ff <= 1'b0;
    end else if (ce_i) begin
      raw_ff <= raw_in;
      if (raw_ff == filt_ff) begin
        fcnt_ff <= 4'h0;
      end else if (fcnt_ff + 4'h1 >= flen) begin
        filt_ff <= raw_ff;
        fcnt_ff <= 4'h0;
      end else begin
        fcnt_ff <= fcnt_ff + 4'h1;
      end
    end
  end
  assign demod_signal_o = filt_ff;

  logic edge_rise;
  logic edge_fall;
  logic filt_d_ff;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      filt_d_ff <= 1'b0;
    end else if (ce_i) begin
      filt_d_ff <= filt_ff;
    end
  end
  assign edge_rise = demod && filt_ff && !filt_d_ff;
  assign edge_fall = demod && !filt_ff && filt_d_ff;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rise_ff <= 1'b0;
      fall_ff <= 1'b0;
    end else if (ce_i) begin
      if (edge_rise) begin
        rise_ff <= 1'b1;
      end else if (wr_acc && demod && req.paddr == IRPT_OFF_COMMON && req.pwdata[IRPT_C1_INIT8]) begin
        rise_ff <= 1'b0;
      end
      if (edge_fall) begin
        fall_ff <= 1'b1;
      end else if (wr_acc && demod && req.paddr == IRPT_OFF_COMMON && req.pwdata[IRPT_C1_INIT16]) begin
        fall_ff <= 1'b0;
      end
    end
  end

  // Capture from the port-3 pin also requests interrupt two.
  assign irq_two_capture_o = demod && common_ff[IRPT_C1_SEL] && (edge_rise || edge_fall);

  // Output routing and the forced 16-bit output levels.
  always_comb begin
    case (common_ff[IRPT_C1_SUBHI:IRPT_C1_SUBLO])
      IRPT_SUB_LOW:  sixteen_bit_timer_output_o = 1'b0;
      IRPT_SUB_HIGH: sixteen_bit_timer_output_o = 1'b1;
      IRPT_SUB_NORMAL, IRPT_SUB_PING: sixteen_bit_timer_output_o = timer16_out_i;
      default:       sixteen_bit_timer_output_o = 1'b0;
    endcase
  end
  assign timer_output_pin_o    = ctrl8_ff[IRPT_C0_ROUTE] ? out8_ff : port_out_34_i;
  assign combined_output_pin_o = (!demod && common_ff[IRPT_C1_SEL]) ?
                                 (out8_ff | sixteen_bit_timer_output_o) : port_out_36_i;

  // Terminal-count steps as sequences; four of the properties below hang their checks on them.
  sequence s_tc_single;
    ce_i && tc && ctrl8_ff[IRPT_C0_SINGLE] && !start;
  endsequence

  sequence s_tc_repeat;
    ce_i && tc && !ctrl8_ff[IRPT_C0_SINGLE] && !start;
  endsequence

  a_tout_sets : assert property (@(posedge clk_i) disable iff (!rst_n_i) (ce_i && tout_ev) |=> tout_ff)
    else $error("Timeout status not set after terminal count.");
  a_tout_holds : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (tout_ff && !(wr_acc && req.paddr == IRPT_OFF_CTRL8 && req.pwdata[IRPT_C0_TOUT])) |=> tout_ff)
    else $error("Timeout status dropped without a write of one.");
  a_tout_clear : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!tout_ev && wr_acc && req.paddr == IRPT_OFF_CTRL8 && req.pwdata[IRPT_C0_TOUT]) |=> !tout_ff)
    else $error("Timeout status not cleared by a write of one.");

  a_irq_masked : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    timeout_irq_o |-> $past(ctrl8_ff[IRPT_C0_IMASK]) && $past(tout_ev))
    else $error("Timeout interrupt without mask enabled.");
  a_irq_follows : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ce_i && tout_ev && ctrl8_ff[IRPT_C0_IMASK]) |=> timeout_irq_o)
    else $error("Enabled timeout interrupt did not follow terminal count.");

  a_start_level : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    start |=> out8_ff == $past(common_ff[IRPT_C1_INIT8]))
    else $error("Output did not take its initial level.");
  a_start_load : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    start |=> cnt_ff == ($past(common_ff[IRPT_C1_INIT8]) ? $past(high_ff) : $past(low_ff)))
    else $error("Start did not load the reload value of the initial level.");

  a_single_stop : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_tc_single |=> state_ff == IRPT_DONE && out8_ff != $past(out8_ff))
    else $error("Single pass did not stop and toggle.");
  a_done_hold : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ce_i && !start && state_ff == IRPT_DONE) |=> $stable(cnt_ff) && $stable(out8_ff))
    else $error("Stopped single-pass timer moved.");
  a_reload_level : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_tc_repeat |=> cnt_ff == (out8_ff ? $past(high_ff) : $past(low_ff)))
    else $error("Reload value does not match the new output level.");
  a_first_quiet : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (start && !ctrl8_ff[IRPT_C0_SINGLE]) |=> !half_ff)
    else $error("Half-cycle phase not cleared on start.");
  a_first_silent : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_tc_repeat ##0 (!half_ff) |=> !timeout_irq_o)
    else $error("First terminal count of a cycle raised an interrupt.");
  a_second_tout : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_tc_repeat ##0 half_ff |=> tout_ff)
    else $error("Second terminal count of a cycle did not set timeout.");

  // Counting and the clock enable.
  a_count_step : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ce_i && !start && state_ff == IRPT_COUNT && tick_i && !tc) |=> cnt_ff == $past(cnt_ff) - 8'h01)
    else $error("Counter did not step down on a tick.");
  a_count_hold : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ce_i && !start && state_ff == IRPT_COUNT && !tick_i) |=> $stable(cnt_ff))
    else $error("Counter moved without a tick.");
  a_wrap_zero : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ce_i && !start && state_ff == IRPT_COUNT && tick_i && cnt_ff == IRPT_CNT_ZERO) |=> cnt_ff == 8'hff)
    else $error("Counter did not wrap from zero.");
  a_ce_freeze : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !ce_i |=> $stable(cnt_ff) && $stable(out8_ff) && $stable(tout_ff) && $stable(ctrl8_ff) && $stable(common_ff))
    else $error("State moved while the clock enable was low.");

  // Pin routing and forced levels.
  a_route_pin : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !ctrl8_ff[IRPT_C0_ROUTE] |-> timer_output_pin_o == port_out_34_i)
    else $error("Timer pin not left to port output.");
  a_route_comb : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (demod || !common_ff[IRPT_C1_SEL]) |-> combined_output_pin_o == port_out_36_i)
    else $error("Shared pin not left to port output.");
  a_force_low : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!demod && common_ff[IRPT_C1_SUBHI:IRPT_C1_SUBLO] == IRPT_SUB_LOW) |-> !sixteen_bit_timer_output_o)
    else $error("Sixteen-bit output not forced low.");
  a_force_high : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!demod && common_ff[IRPT_C1_SUBHI:IRPT_C1_SUBLO] == IRPT_SUB_HIGH) |-> sixteen_bit_timer_output_o)
    else $error("Sixteen-bit output not forced high.");

  // Demodulation input path.
  a_rise_flag : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ce_i && edge_rise) |=> rise_ff)
    else $error("Rising edge flag not set.");
  a_fall_flag : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ce_i && edge_fall) |=> fall_ff)
    else $error("Falling edge flag not set.");
  a_capture_sel : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    irq_two_capture_o |-> demod && common_ff[IRPT_C1_SEL])
    else $error("Capture request raised without the port-3 input selected.");
  a_filter_hold : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ce_i && raw_ff != filt_ff && fcnt_ff + 4'h1 < flen) |=> $stable(filt_ff))
    else $error("Filtered input changed before the filter time ran out.");

endmodule : irpt_timer

// *** logic/irpt_pkg.sv ***
// Package with register map, field positions and types for the 8-bit IR pulse timer.
package irpt_pkg;

  localparam logic [7:0] IRPT_OFF_CTRL8  = 8'h00;
  localparam logic [7:0] IRPT_OFF_COMMON = 8'h04;
  localparam logic [7:0] IRPT_OFF_HIGH   = 8'h08;
  localparam logic [7:0] IRPT_OFF_LOW    = 8'h0c;
  localparam logic [7:0] IRPT_OFF_STAT   = 8'h10;

  // Fields of timer8_control.
  localparam int IRPT_C0_EN    = 7;
  localparam int IRPT_C0_SINGLE = 6;
  localparam int IRPT_C0_TOUT  = 5;
  localparam int IRPT_C0_CLKLO = 3;
  localparam int IRPT_C0_CLKHI = 4;
  localparam int IRPT_C0_IMASK = 1;
  localparam int IRPT_C0_ROUTE = 0;

  // Fields of timer_common_control.
  localparam int IRPT_C1_MODELO = 6;
  localparam int IRPT_C1_MODEHI = 7;
  localparam int IRPT_C1_SEL    = 5;
  localparam int IRPT_C1_SUBLO  = 2;
  localparam int IRPT_C1_SUBHI  = 3;
  localparam int IRPT_C1_INIT8  = 1;
  localparam int IRPT_C1_INIT16 = 0;

  localparam logic [7:0] IRPT_RST_BYTE = 8'h00;
  localparam logic [7:0] IRPT_CNT_ONE  = 8'h01;
  localparam logic [7:0] IRPT_CNT_ZERO = 8'h00;

  localparam logic [1:0] IRPT_SUB_NORMAL = 2'h0;
  localparam logic [1:0] IRPT_SUB_PING   = 2'h1;
  localparam logic [1:0] IRPT_SUB_LOW    = 2'h2;
  localparam logic [1:0] IRPT_SUB_HIGH   = 2'h3;

  localparam int IRPT_CLK_NS   = 100;
  localparam int IRPT_FILT4_NS = 400;
  localparam int IRPT_FILT8_NS = 800;
  localparam logic [3:0] IRPT_FILT4_CYC = 4'(IRPT_FILT4_NS / IRPT_CLK_NS);
  localparam logic [3:0] IRPT_FILT8_CYC = 4'(IRPT_FILT8_NS / IRPT_CLK_NS);

  typedef enum logic [1:0] {
    IRPT_IDLE  = 2'b00,
    IRPT_FIRST = 2'b01,
    IRPT_COUNT = 2'b10,
    IRPT_DONE  = 2'b11
  } irpt_state_t;

  typedef struct packed {
    logic       psel;
    logic       penable;
    logic       pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } irpt_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } irpt_apb_rsp_t;

endpackage : irpt_pkg

// *** sim/irpt_ir_pins.sv ***
// Model of the infrared receive pins that feed the demodulation inputs.
module irpt_ir_pins (
  input  wire logic clk_i,
  input  wire logic sel_i,
  input  wire logic level_i,
  output logic      port2_o,
  output logic      port3_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic noise_ff = 1'b0;
  // The unselected pin toggles every cycle, so a wrong input choice shows up as spurious edges.
  always @(posedge clk_i) noise_ff <= ~noise_ff;
  assign port2_o = sel_i ? noise_ff : level_i;
  assign port3_o = sel_i ? level_i : noise_ff;
endmodule : irpt_ir_pins

// *** sim/irpt_timer_tb_top.sv ***
// Self-checking bench for the 8-bit IR pulse timer.
module irpt_timer_tb_top import irpt_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic          clk_i = 1'b0;
  logic          rst_n_i = 1'b0;
  logic          tick = 1'b0;
  logic          ce = 1'b1;
  logic          p34 = 1'b0, p36 = 1'b0, t16 = 1'b0, lvl = 1'b0, sel = 1'b0;
  irpt_apb_req_t req = '0;
  wire irpt_apb_rsp_t rsp;
  logic [31:0]   rd;
  logic          err, pin8, pin36, o16, dsig, tirq, interrupt_request_two, pt2, pt3;
  int            fail_count = 0, check_count = 0, cyc = 0, irqn = 0, irq2n = 0, seed, h, l, n2, d;

  irpt_timer u_dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce), .psel_i(req.psel), .penable_i(req.penable),
    .pwrite_i(req.pwrite), .paddr_i(req.paddr), .pwdata_i(req.pwdata), .prdata_o(rsp.prdata),
    .pready_o(rsp.pready), .pslverr_o(rsp.pslverr), .tick_i(tick), .port_out_34_i(p34),
    .port_out_36_i(p36), .timer16_out_i(t16), .port2_input_pin_i(pt2), .port3_input_pin_i(pt3),
    .timer_output_pin_o(pin8), .combined_output_pin_o(pin36), .sixteen_bit_timer_output_o(o16),
    .demod_signal_o(dsig), .timeout_irq_o(tirq), .irq_two_capture_o(interrupt_request_two)
  );
  irpt_ir_pins u_pins (.clk_i(clk_i), .sel_i(sel), .level_i(lvl), .port2_o(pt2), .port3_o(pt3));

  always #50 clk_i = ~clk_i;

  always @(posedge clk_i) begin
    cyc++;
    if (tirq === 1'b1) irqn++;
    if (interrupt_request_two === 1'b1) irq2n++;
    if (cyc == 30000) begin
      fail_count++;
      stop_test();
    end
  end

  task automatic stop_test();
    if (fail_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string s);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %0t %s", $time, s);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dt);
    int n;
    n = 0;
    req <= '{1'b1, 1'b0, w, a, dt};
    @(posedge clk_i);
    req.penable <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (rsp.pready !== 1'b1 && n < 16);
    chk(32'(rsp.pready), 32'h1, "apb no ready");
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    @(posedge clk_i);
  endtask : apb

  task automatic wr(input logic [7:0] a, input int dt);
    apb(1'b1, a, 32'(dt));
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string s);
    apb(1'b0, a, 32'h0);
    chk(rd & m, e, s);
  endtask : rdc

  task automatic w(input int n);
    repeat (n) @(posedge clk_i);
  endtask : w

  task automatic tk(input int n);
    repeat (n) begin
      tick <= 1'b1;
      @(posedge clk_i);
      tick <= 1'b0;
      repeat (1 + $urandom_range(2)) @(posedge clk_i);
    end
  endtask : tk

  // Checks the 8-bit output level, the timeout status bit and the count of timeout pulses.
  task automatic st(input logic p, input int ni, input logic t, input string s);
    apb(1'b0, IRPT_OFF_CTRL8, 32'h0);
    chk({pin8, rd[5], 30'(irqn)}, {p, t, 30'(ni)}, s);
  endtask : st

  function automatic int cnt();
    return 2 + $urandom_range(6);
  endfunction : cnt

  function automatic logic f16(input logic [1:0] s, input logic t);
    return s[1] ? s[0] : t;
  endfunction : f16

  initial begin
    seed = $urandom(32'h0912);
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    for (int i = 0; i < 4; i++) rdc(8'(4 * i), 32'hffffffff, 32'h0, "reset value");
    rdc(8'h14, 32'hffffffff, 32'h0, "unmapped read");
    chk(32'(err), 32'h1, "unmapped error");
    wr(IRPT_OFF_HIGH, 32'hffffffa5);
    rdc(IRPT_OFF_HIGH, 32'hffffffff, 32'ha5, "reload readback");
    {p34, p36, t16} <= 3'($urandom);
    w(2);
    chk(32'({pin8, pin36, o16}), 32'({p34, p36, t16}), "port pass-through");
    for (int s = 0; s < 4; s++) begin
      wr(IRPT_OFF_COMMON, s << 2);
      w(1);
      chk(32'(o16), 32'(f16(2'(s), t16)), "sub-mode");
    end
    wr(IRPT_OFF_CTRL8, 32'h20);
    l = cnt();
    wr(IRPT_OFF_HIGH, cnt());
    wr(IRPT_OFF_LOW, l);
    wr(IRPT_OFF_COMMON, 0);
    wr(IRPT_OFF_CTRL8, 32'hc3);
    st(1'b0, 0, 1'b0, "initial low");
    ce <= 1'b0;
    tk(2);
    ce <= 1'b1;
    tk(l - 1);
    st(1'b0, 0, 1'b0, "early terminal");
    tk(1);
    st(1'b1, 1, 1'b1, "single pass end");
    tk(3);
    st(1'b1, 1, 1'b1, "single pass stop");
    wr(IRPT_OFF_CTRL8, 32'h43);
    st(1'b1, 1, 1'b1, "status kept");
    wr(IRPT_OFF_CTRL8, 32'h20);
    rdc(IRPT_OFF_CTRL8, 32'h20, 32'h0, "status cleared");
    h = cnt();
    l = cnt();
    wr(IRPT_OFF_HIGH, h);
    wr(IRPT_OFF_LOW, l);
    wr(IRPT_OFF_COMMON, 32'h2);
    wr(IRPT_OFF_CTRL8, 32'h81);
    st(1'b1, 1, 1'b0, "initial high");
    tk(h);
    st(1'b0, 1, 1'b0, "first terminal");
    h = cnt();
    wr(IRPT_OFF_HIGH, h);
    tk(l);
    st(1'b1, 1, 1'b1, "second terminal");
    wr(IRPT_OFF_COMMON, 32'h22);
    t16 <= 1'b0;
    tk(h - 1);
    st(1'b1, 1, 1'b1, "new reload");
    chk(32'(pin36), 32'h1, "combined high");
    tk(1);
    st(1'b0, 1, 1'b1, "repeat reload");
    chk(32'(pin36), 32'h0, "combined low");
    wr(IRPT_OFF_CTRL8, 32'h20);
    wr(IRPT_OFF_LOW, 0);
    wr(IRPT_OFF_COMMON, 0);
    wr(IRPT_OFF_CTRL8, 32'hc3);
    tk(255);
    st(1'b0, 1, 1'b0, "wrap early");
    rdc(IRPT_OFF_STAT, 32'hff, 32'h1, "count readback");
    tk(1);
    st(1'b1, 2, 1'b1, "full count");
    for (int s = 0; s < 2; s++) begin
      sel <= 1'(s);
      lvl <= 1'b0;
      d = ((s + 1) << 6) | (s << 5) | 3;
      wr(IRPT_OFF_COMMON, d);
      w(4);
      wr(IRPT_OFF_COMMON, d);
      rdc(IRPT_OFF_COMMON, 32'h3, 32'h0, "flags idle");
      n2 = irq2n;
      lvl <= 1'b1;
      w(4);
      rdc(IRPT_OFF_COMMON, 32'h3, 32'h2, "rise flag");
      chk(32'(dsig), 32'h1, "demod level");
      lvl <= 1'b0;
      w(4);
      rdc(IRPT_OFF_COMMON, 32'h3, 32'h3, "fall flag");
      chk(32'(irq2n - n2), 32'(2 * s), "capture request");
      wr(IRPT_OFF_COMMON, d & ~1);
      rdc(IRPT_OFF_COMMON, 32'h3, 32'h1, "one flag cleared");
    end
    sel <= 1'b0;
    for (int f = 1; f < 3; f++) begin
      lvl <= 1'b0;
      d = 32'h43 | (f << 2);
      wr(IRPT_OFF_COMMON, d);
      w(12);
      wr(IRPT_OFF_COMMON, d);
      lvl <= 1'b1;
      w(4 * f - 2);
      lvl <= 1'b0;
      w(12);
      rdc(IRPT_OFF_COMMON, 32'h3, 32'h0, "glitch passed");
      lvl <= 1'b1;
      w(12);
      rdc(IRPT_OFF_COMMON, 32'h3, 32'h2, "filtered edge");
    end
    stop_test();
  end
endmodule : irpt_timer_tb_top
